// File: core/hcis_cfg.svh
// Register offsets, field positions and reset values of the host channel interrupt block
`ifndef HCIS_CFG_SVH
`define HCIS_CFG_SVH

// Offsets are not multiples of four: these are indices, byte address is four times the index
`define HCIS_IDX_CTRL_STAT    8'hE5
`define HCIS_IDX_BULK_STAT    8'hE6
`define HCIS_IDX_GENB_STAT    8'hE7
`define HCIS_IDX_GENC_STAT    8'hE8
`define HCIS_IDX_GEND_STAT    8'hE9
`define HCIS_IDX_GENE_STAT    8'hEA
`define HCIS_IDX_LINK_EN      8'hF0
`define HCIS_IDX_STATE_EN     8'hF1
`define HCIS_IDX_BUF_EN       8'hF2
`define HCIS_IDX_CHAN_EN0     8'hC0
`define HCIS_IDX_CTRL         8'hC8
`define HCIS_IDX_SUMMARY      8'hC9
`define HCIS_IDX_IRQ_STAT     8'hCA
`define HCIS_IDX_IRQ_MASK     8'hCB
`define HCIS_IDX_RESULT0      8'hD0

`define HCIS_BIT_DONE         7
`define HCIS_BIT_ACK          6
`define HCIS_BIT_ERR          5
`define HCIS_BIT_COND         4
`define HCIS_BIT_ASSIST_DONE  1
`define HCIS_BIT_ASSIST_ABORT 0

`define HCIS_CTRL_CH_MASK     8'hF3
`define HCIS_GEN_CH_MASK      8'hF0
`define HCIS_LINK_EN_MASK     8'h1F
`define HCIS_STATE_EN_MASK    8'h0F
`define HCIS_BUF_EN_MASK      8'h77
`define HCIS_RESET_VAL        8'h00
`define HCIS_RETRY_LIMIT      2'h3

`endif

// File: core/hcis_pkg.sv
// Types shared by the host channel interrupt block
package hcis_pkg;
   typedef enum logic [1:0] {
      HCIS_XFER_CTRL,
      HCIS_XFER_BULK,
      HCIS_XFER_INTR,
      HCIS_XFER_ISO
   } hcis_xfer_t;

   typedef enum logic [1:0] {
      HCIS_STAGE_FIRST,
      HCIS_STAGE_DATA,
      HCIS_STAGE_STATUS
   } hcis_stage_t;
endpackage : hcis_pkg

// File: core/hcis_top.sv
// Host channel interrupt status, enables, summary and APB slave
`timescale 1ns/1ps
`default_nettype none
`include "hcis_cfg.svh"

// What this block does
// - Writing one clears a channel flag
// - Control done flag after all stages end
// - Control ack count counts data stage only
// - Retry error sets transaction error flag
// - Three retries (general channels: bulk and interrupt only) or stall sets condition flag
// - Go bit raise sets condition, reports result
// - Control assist done on completion or stop
// - Control assist abort on error or stop
// - Bulk done flag after all transports end
// - Bulk ack count counts data transport only
// - Bulk assist done on status or stop
// - Bulk assist abort on error or stop
// - Isochronous buffer overrun sets error flag
// - General channel condition flag, low bits reserved
// - Enable bits gate status into summary
// - Link enables frozen in low power states
// - Summary bit reflects enabled channel factors
module hcis_top #(
   parameter int NCH = 6
) (
   input  wire logic                 sys_clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [11:0]          paddr_i,
   input  wire logic [31:0]          pwdata_i,
   input  wire logic [3:0]           pstrb_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   input  wire logic [NCH-1:0]       xfer_done_i,
   input  wire logic [NCH-1:0]       txn_ok_i,
   input  wire logic [NCH-1:0]       txn_retry_err_i,
   input  wire logic [NCH-1:0]       txn_halt_i,
   input  wire logic [NCH-1:0]       buf_overrun_i,
   input  wire logic [NCH-1:0]       go_raise_i,
   input  wire logic [NCH*4-1:0]     result_code_i,
   input  wire logic [NCH*2-1:0]     xfer_type_i,
   input  wire logic [1:0]           assist_active_i,
   input  wire logic [3:0]           assist_stage_i,
   input  wire logic [1:0]           assist_go_clear_i,
   input  wire logic [1:0]           assist_stop_done_i,
   input  wire logic                 clock_only_active_state_i,
   input  wire logic                 device_active_state_i,
   input  wire logic [4:0]           link_stat_i,
   input  wire logic [3:0]           state_stat_i,
   input  wire logic [7:0]           buf_stat_i,
   output logic [2:0]                top_irq_summary_o,
   output logic [NCH-1:0]            chan_summary_o,
   output logic                      irq_o
);

   // ****************************************
   // Register bus decode
   // ****************************************
   logic       acc;
   logic       wr;
   logic [7:0] idx;
   logic       mapped;
   assign acc = psel_i & penable_i;
   assign wr  = acc & pwrite_i & pstrb_i[0];
   assign idx = paddr_i[9:2];

   // ****************************************
   // Channel flags and counters
   // ****************************************
   logic [7:0] stat_q   [NCH];
   logic [7:0] chen_q   [NCH];
   logic [3:0] result_q [NCH];
   logic [7:0] ack_target_q [NCH];
   logic [7:0] ack_cnt_q    [NCH];
   logic [1:0] retry_q      [NCH];
   logic [NCH-1:0] ch_summary;
   logic frozen;
   logic stop_ok_ctrl;
   assign frozen = clock_only_active_state_i | device_active_state_i;

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic [7:0] set_v;
         logic [7:0] clr_v;
         logic [7:0] imp;
         logic       assist;
         logic       in_data;
         logic       in_status;
         logic       counts;
         logic       three;
         logic       halt_err;
         logic       iso_ovr;
         logic       asst_done_set;
         logic       asst_abort_set;
         assign imp    = (c < 2) ? `HCIS_CTRL_CH_MASK : `HCIS_GEN_CH_MASK;
         assign three  = txn_retry_err_i[c] & (retry_q[c] == (`HCIS_RETRY_LIMIT - 2'h1));
         assign counts = txn_ok_i[c] & (~assist | in_data);

         // ****************************************
         // Stage tracking, assisted channels only
         // ****************************************
         if (c < 2) begin : g_assist
            assign assist    = assist_active_i[c];
            assign in_data   = (assist_stage_i[c*2+:2] == hcis_pkg::HCIS_STAGE_DATA);
            assign in_status = (assist_stage_i[c*2+:2] == hcis_pkg::HCIS_STAGE_STATUS);
            assign halt_err  = three;
            assign iso_ovr   = 1'b0;
            // Normal completion, or stop after a clean status stage
            assign asst_done_set  = assist & xfer_done_i[c] & in_status
                                  | assist_go_clear_i[c] & assist_stop_done_i[c]
                                    & in_status & ~txn_retry_err_i[c];
            assign asst_abort_set = assist & (txn_retry_err_i[c] | txn_halt_i[c])
                                  | assist_go_clear_i[c] & assist_stop_done_i[c]
                                    & (~in_status | txn_retry_err_i[c]);
         end else begin : g_general
            assign assist    = 1'b0;
            assign in_data   = 1'b1;
            assign in_status = 1'b0;
            // Three retries only halt bulk and interrupt pipes
            assign halt_err  = three & ((xfer_type_i[c*2+:2] == hcis_pkg::HCIS_XFER_BULK)
                                      | (xfer_type_i[c*2+:2] == hcis_pkg::HCIS_XFER_INTR));
            assign iso_ovr   = buf_overrun_i[c] & (xfer_type_i[c*2+:2] == hcis_pkg::HCIS_XFER_ISO);
            assign asst_done_set  = 1'b0;
            assign asst_abort_set = 1'b0;
         end

         // ****************************************
         // Flag set and clear terms
         // ****************************************
         always_comb begin
            set_v = 8'h00;
            // Under assistance the engine reports the whole sequence as one done
            set_v[`HCIS_BIT_DONE]         = xfer_done_i[c] & (~assist | in_status);
            set_v[`HCIS_BIT_ACK]          = counts & (ack_cnt_q[c] + 8'h01 == ack_target_q[c]);
            set_v[`HCIS_BIT_ERR]          = txn_retry_err_i[c] | iso_ovr;
            set_v[`HCIS_BIT_COND]         = halt_err | txn_halt_i[c] | go_raise_i[c];
            set_v[`HCIS_BIT_ASSIST_DONE]  = asst_done_set;
            set_v[`HCIS_BIT_ASSIST_ABORT] = asst_abort_set;
            set_v = set_v & imp;
            clr_v = (wr && idx == `HCIS_IDX_CTRL_STAT + 8'(c)) ? pwdata_i[7:0] : 8'h00;
         end

         // Set wins over a simultaneous write-one clear
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               stat_q[c] <= `HCIS_RESET_VAL;
            end else begin
               stat_q[c] <= (stat_q[c] & ~clr_v) | set_v;
            end
         end

         // ****************************************
         // Ack count, retry run and result code
         // ****************************************
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               ack_cnt_q[c] <= 8'h00;
            end else if (counts) begin
               ack_cnt_q[c] <= set_v[`HCIS_BIT_ACK] ? 8'h00 : ack_cnt_q[c] + 8'h01;
            end
         end

         // An ok transaction, or the third retry itself, ends the run
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               retry_q[c] <= 2'h0;
            end else if (txn_ok_i[c] | three) begin
               retry_q[c] <= 2'h0;
            end else if (txn_retry_err_i[c]) begin
               retry_q[c] <= retry_q[c] + 2'h1;
            end
         end

         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               result_q[c] <= 4'h0;
            end else if (go_raise_i[c]) begin
               result_q[c] <= result_code_i[c*4+:4];
            end
         end

         // ****************************************
         // Channel enables and ack target
         // ****************************************
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               chen_q[c]       <= `HCIS_RESET_VAL;
               ack_target_q[c] <= 8'h01;
            end else if (wr && idx == `HCIS_IDX_CHAN_EN0 + 8'(c)) begin
               chen_q[c]       <= pwdata_i[7:0] & imp;
               ack_target_q[c] <= pwdata_i[15:8];
            end
         end

         assign ch_summary[c] = |(stat_q[c] & chen_q[c]);
      end
   endgenerate
   assign stop_ok_ctrl = 1'b0;

   // ****************************************
   // Link, state and buffer enables
   // ****************************************
   logic [7:0] link_en_q;
   logic [7:0] state_en_q;
   logic [7:0] buf_en_q;

   // Link-synchronous bits have no clock in the low power states
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         link_en_q <= `HCIS_RESET_VAL;
      end else if (wr && idx == `HCIS_IDX_LINK_EN && !frozen) begin
         link_en_q <= pwdata_i[7:0] & `HCIS_LINK_EN_MASK;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_en_q <= `HCIS_RESET_VAL;
      end else if (wr && idx == `HCIS_IDX_STATE_EN && !frozen) begin
         state_en_q <= pwdata_i[7:0] & `HCIS_STATE_EN_MASK;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         buf_en_q <= `HCIS_RESET_VAL;
      end else if (wr && idx == `HCIS_IDX_BUF_EN) begin
         buf_en_q <= pwdata_i[7:0] & `HCIS_BUF_EN_MASK;
      end
   end

   // ****************************************
   // Summary and interrupt
   // ****************************************
   logic [2:0]     top_sum;
   logic [NCH+2:0] events;
   logic [NCH+2:0] prev_q;
   logic [NCH+2:0] irq_stat_q;
   logic [NCH+2:0] irq_mask_q;
   logic [NCH+2:0] irq_clr;
   assign top_sum[0] = |(link_stat_i & link_en_q[4:0]);
   assign top_sum[1] = |(state_stat_i & state_en_q[3:0]);
   assign top_sum[2] = |(buf_stat_i & buf_en_q);
   assign events  = {top_sum, ch_summary} & ~prev_q;
   assign irq_clr = (wr && idx == `HCIS_IDX_IRQ_STAT) ? pwdata_i[NCH+2:0] : '0;

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         prev_q <= '0;
      end else begin
         prev_q <= {top_sum, ch_summary};
      end
   end

   // A rising summary bit wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | events;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_mask_q <= '0;
      end else if (wr && idx == `HCIS_IDX_IRQ_MASK) begin
         irq_mask_q <= pwdata_i[NCH+2:0];
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   // Summary outputs are registered, one cycle behind the flags
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         top_irq_summary_o <= 3'h0;
      end else begin
         top_irq_summary_o <= top_sum;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         chan_summary_o <= '0;
      end else begin
         chan_summary_o <= ch_summary;
      end
   end

   // Built from the next status value so the line follows the status bit
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |((irq_stat_q & ~irq_clr | events) & irq_mask_q);
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   logic [31:0] rdata;
   logic [7:0]  stat_off;
   logic [7:0]  chen_off;
   logic [7:0]  res_off;
   // Offsets are cut to an entry index only after the range test passes
   assign stat_off = idx - `HCIS_IDX_CTRL_STAT;
   assign chen_off = idx - `HCIS_IDX_CHAN_EN0;
   assign res_off  = idx - `HCIS_IDX_RESULT0;

   always_comb begin
      rdata  = 32'h0000_0000;
      mapped = 1'b1;
      if (idx >= `HCIS_IDX_CTRL_STAT && idx < `HCIS_IDX_CTRL_STAT + 8'(NCH)) begin
         rdata[7:0] = stat_q[stat_off[2:0]];
      end else if (idx >= `HCIS_IDX_CHAN_EN0 && idx < `HCIS_IDX_CHAN_EN0 + 8'(NCH)) begin
         rdata[15:0] = {ack_target_q[chen_off[2:0]], chen_q[chen_off[2:0]]};
      end else if (idx >= `HCIS_IDX_RESULT0 && idx < `HCIS_IDX_RESULT0 + 8'(NCH)) begin
         rdata[3:0] = result_q[res_off[2:0]];
      end else begin
         unique case (idx)
            `HCIS_IDX_LINK_EN:  rdata[7:0] = link_en_q;
            `HCIS_IDX_STATE_EN: rdata[7:0] = state_en_q;
            `HCIS_IDX_BUF_EN:   rdata[7:0] = buf_en_q;
            `HCIS_IDX_SUMMARY:  rdata[NCH+2:0] = {top_sum, ch_summary};
            `HCIS_IDX_IRQ_STAT: rdata[NCH+2:0] = irq_stat_q;
            `HCIS_IDX_IRQ_MASK: rdata[NCH+2:0] = irq_mask_q;
            default:            mapped = 1'b0;
         endcase
      end
   end

   // ****************************************
   // Bus answer
   // ****************************************
   // Zero-wait slave: answer in the first access cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= psel_i & ~penable_i & ~mapped;
      end
   end

   // Read data is captured at setup, so it stands during the access cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else begin
         prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rdata : 32'h0000_0000;
      end
   end

   logic unused;
   assign unused = ^{stop_ok_ctrl, xfer_type_i[3:0], pstrb_i[3:1], paddr_i[11:10], paddr_i[1:0],
                     pwdata_i[31:16], stat_off[7:3], chen_off[7:3], res_off[7:3]};

endmodule : hcis_top
`default_nettype wire

// File: testbench/hcis_sva.sv
// Port checker for the host channel interrupt block
`timescale 1ns/1ps
`default_nettype none
module hcis_sva #(
   parameter int NCH = 6
) (
   input wire logic           sys_clk_i,
   input wire logic           sys_rst_i,
   input wire logic           psel_i,
   input wire logic           penable_i,
   input wire logic           pready_o,
   input wire logic           pslverr_o,
   input wire logic [4:0]     link_stat_i,
   input wire logic [3:0]     state_stat_i,
   input wire logic [7:0]     buf_stat_i,
   input wire logic [2:0]     top_irq_summary_o,
   input wire logic [NCH-1:0] chan_summary_o,
   input wire logic           irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ****************
   // Bus and summary
   // ****************
   ready_setup_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
   ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
   ready_access_a: assert property (pready_o |-> psel_i && penable_i) else $error("ready outside access");
   err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   link_gate_a: assert property (top_irq_summary_o[0] |-> $past(|link_stat_i) || $past(|link_stat_i, 2))
      else $error("link summary without factor");
   state_gate_a: assert property (top_irq_summary_o[1] |-> $past(|state_stat_i) || $past(|state_stat_i, 2))
      else $error("state summary without factor");
   buf_gate_a: assert property (top_irq_summary_o[2] |-> $past(|buf_stat_i) || $past(|buf_stat_i, 2))
      else $error("buffer summary without factor");
   rst_clean_a: assert property ($fell(sys_rst_i) |-> !irq_o && !pready_o && chan_summary_o == '0)
      else $error("outputs not clear after reset");
   cover property ($rose(irq_o));
   cover property (pslverr_o);
   cover property ($rose(chan_summary_o[0]));
endmodule : hcis_sva
`default_nettype wire

// File: testbench/hcis_usb_dev.sv
// Attached device model: one-cycle channel event pulses
`timescale 1ns/1ps
`default_nettype none
module hcis_usb_dev (
   input  wire logic        clk_i,
   output logic [5:0]       done_o,
   output logic [5:0]       ok_o,
   output logic [5:0]       err_o,
   output logic [5:0]       halt_o,
   output logic [5:0]       ovr_o,
   output logic [5:0]       go_o,
   output logic [23:0]      code_o
);
   initial begin
      {done_o, ok_o, err_o, halt_o, ovr_o, go_o} = '0;
      code_o = '0;
   end
   // Kind: 0 done, 1 ok, 2 retry error, 3 halt, 4 overrun, 5 go
   task automatic ev(input int k, input int ch, input logic [3:0] c);
      logic [5:0] b;
      b = 6'h01 << ch;
      @(posedge clk_i);
      case (k)
         0: done_o <= b;
         1: ok_o <= b;
         2: err_o <= b;
         3: halt_o <= b;
         4: ovr_o <= b;
         default: go_o <= b;
      endcase
      code_o[ch*4 +: 4] <= c;
      @(posedge clk_i);
      {done_o, ok_o, err_o, halt_o, ovr_o, go_o} <= '0;
   endtask : ev
endmodule : hcis_usb_dev
`default_nettype wire

// File: testbench/usb_host_channel_irq_status_tb_top.sv
// Self-checking bench for the host channel interrupt block
`timescale 1ns/1ps
`default_nettype none
module usb_host_channel_irq_status_tb_top;
   logic        clk, rst, psel, pen, pwr, rdy, perr, irq, er_v, frz0, frz1;
   logic [11:0] padr, xtype;
   logic [31:0] pwd, rdata, rd_v;
   logic [5:0]  done, ok, rerr, halt, ovr, go, csum;
   logic [23:0] code;
   logic [3:0]  stage, sstat;
   logic [1:0]  aact, gclr, sdone;
   logic [4:0]  lstat;
   logic [7:0]  bstat;
   logic [2:0]  tsum;
   int          fails, n_checks, cyc;
   hcis_top u_dut (
      .sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(padr), .pwdata_i(pwd), .pstrb_i(4'hF), .prdata_o(rdata), .pready_o(rdy),
      .pslverr_o(perr), .xfer_done_i(done), .txn_ok_i(ok), .txn_retry_err_i(rerr),
      .txn_halt_i(halt), .buf_overrun_i(ovr), .go_raise_i(go), .result_code_i(code),
      .xfer_type_i(xtype), .assist_active_i(aact), .assist_stage_i(stage),
      .assist_go_clear_i(gclr), .assist_stop_done_i(sdone), .clock_only_active_state_i(frz0),
      .device_active_state_i(frz1), .link_stat_i(lstat), .state_stat_i(sstat),
      .buf_stat_i(bstat), .top_irq_summary_o(tsum), .chan_summary_o(csum), .irq_o(irq));
   hcis_usb_dev u_dev (.clk_i(clk), .done_o(done), .ok_o(ok), .err_o(rerr), .halt_o(halt),
      .ovr_o(ovr), .go_o(go), .code_o(code));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Holds the request until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      padr <= {2'h0, a, 2'h0};
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      do @(posedge clk); while (rdy !== 1'h1);
      rd_v = rdata;
      er_v = perr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd_v, e);
   endtask : rd
   task automatic t_regs();
      for (int i = 0; i < 9; i++) rd(i < 6 ? 8'hE5 + i[7:0] : 8'hEA + i[7:0], 32'h0);
      apb(1'h0, 8'h40, 32'h0);
      chk({31'h0, er_v}, 32'h1);
      for (int i = 0; i < 6; i++) wr(8'hC0 + i[7:0], 32'h2FF);
   endtask : t_regs
   task automatic t_ctrl();
      u_dev.ev(0, 0, 4'h0);
      rd(8'hE5, 32'h80);
      chk({26'h0, csum}, 32'h1);
      wr(8'hE5, 32'h0);
      rd(8'hE5, 32'h80);
      wr(8'hE5, 32'h80);
      rd(8'hE5, 32'h0);
      chk({26'h0, csum}, 32'h0);
   endtask : t_ctrl
   task automatic t_err();
      u_dev.ev(2, 1, 4'h0);
      rd(8'hE6, 32'h20);
      repeat (2) u_dev.ev(2, 1, 4'h0);
      rd(8'hE6, 32'h30);
      u_dev.ev(4, 2, 4'h0);
      rd(8'hE7, 32'h0);
      u_dev.ev(3, 2, 4'h0);
      rd(8'hE7, 32'h10);
      u_dev.ev(4, 3, 4'h0);
      rd(8'hE8, 32'h20);
      u_dev.ev(5, 4, 4'hA);
      rd(8'hE9, 32'h10);
      rd(8'hD4, 32'hA);
      for (int i = 0; i < 6; i++) wr(8'hE5 + i[7:0], 32'hFF);
   endtask : t_err
   task automatic t_stop(input logic [3:0] s, input logic [31:0] e);
      stage <= s;
      sdone <= 2'h3;
      @(posedge clk);
      sdone <= 2'h0;
      rd(8'hE5, e);
      rd(8'hE6, e);
      wr(8'hE5, 32'hFF);
      wr(8'hE6, 32'hFF);
   endtask : t_stop
   task automatic t_asst();
      aact <= 2'h3;
      for (int c = 0; c < 2; c++) repeat (2) u_dev.ev(1, c, 4'h0);
      rd(8'hE5, 32'h0);
      rd(8'hE6, 32'h0);
      stage <= 4'h5;
      for (int c = 0; c < 2; c++) repeat (2) u_dev.ev(1, c, 4'h0);
      rd(8'hE5, 32'h40);
      rd(8'hE6, 32'h40);
      stage <= 4'hA;
      u_dev.ev(0, 0, 4'h0);
      u_dev.ev(0, 1, 4'h0);
      rd(8'hE5, 32'hC2);
      rd(8'hE6, 32'hC2);
      wr(8'hE5, 32'hFF);
      wr(8'hE6, 32'hFF);
      stage <= 4'h5;
      u_dev.ev(2, 0, 4'h0);
      u_dev.ev(3, 1, 4'h0);
      rd(8'hE5, 32'h21);
      rd(8'hE6, 32'h11);
      wr(8'hE5, 32'hFF);
      wr(8'hE6, 32'hFF);
      gclr <= 2'h3;
      t_stop(4'h5, 32'h1);
      t_stop(4'hA, 32'h2);
      {aact, gclr, stage} <= '0;
   endtask : t_asst
   task automatic t_sie();
      for (int s = 0; s < 2; s++) begin
         {frz1, frz0} <= 2'h1 << s;
         wr(8'hF0, 32'h1F);
         wr(8'hF1, 32'hF);
         rd(8'hF0, 32'h0);
         rd(8'hF1, 32'h0);
      end
      {frz1, frz0} <= 2'h0;
      wr(8'hF0, 32'h1F);
      wr(8'hF1, 32'hF);
      wr(8'hF2, 32'h77);
      rd(8'hF1, 32'hF);
      {lstat, sstat, bstat} <= {5'h1, 4'h1, 8'h10};
      repeat (3) @(posedge clk);
      chk({29'h0, tsum}, 32'h7);
      wr(8'hF2, 32'h0);
      repeat (2) @(posedge clk);
      chk({29'h0, tsum}, 32'h3);
      {lstat, sstat, bstat} <= '0;
   endtask : t_sie
   task automatic t_irq();
      wr(8'hCA, 32'h1FF);
      wr(8'hCB, 32'h1FF);
      u_dev.ev(0, 5, 4'h0);
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(8'hEA, 32'h80);
      wr(8'hCA, 32'h1FF);
      wr(8'hCB, 32'h0);
      u_dev.ev(0, 5, 4'h0);
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
   endtask : t_irq
   task automatic test_done();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   initial begin
      {psel, pen, pwr, padr, pwd, aact, gclr, sdone, stage} = '0;
      {frz0, frz1, lstat, sstat, bstat} = '0;
      xtype = 12'h0D4;
      rst = 1'h1;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      t_regs();
      t_ctrl();
      t_err();
      t_asst();
      t_sie();
      t_irq();
      test_done();
   end
endmodule : usb_host_channel_irq_status_tb_top
bind hcis_top hcis_sva #(.NCH(NCH)) u_sva (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .link_stat_i(link_stat_i), .state_stat_i(state_stat_i), .buf_stat_i(buf_stat_i),
   .top_irq_summary_o(top_irq_summary_o), .chan_summary_o(chan_summary_o), .irq_o(irq_o));
`default_nettype wire
